// >>> fte_pkg.sv
// Package for the fault and trap exception unit: constants, types, register map
// Summary of operation
// - Bus fault aborts cycle; data immediate, fetch deferred
// - Copy status, set supervisor, clear trace bits
// - Bus fault uses vector 2, pushes frame
// - Bus fault stacks executing instruction address
// - Short frame at boundary, long mid-instruction
// - Bus fault in fault processing halts device; not checked during the prefetch fill
// - Odd fetch address raises address fault, no cycle
// - Address fault uses vector 3, either frame
// - Address fault in fault processing halts device; not checked during the prefetch fill
// - Unconditional trap uses vector 32 plus operand
// - Conditional traps and zero divide trap on error
// - Trace of trapping instruction deferred past return
// - Traps stack next address, plus trapping address
// - Illegal word or bad register move: vector 4; only the bad register move is decoded
// - Breakpoint cycle ended by fault: illegal exception
// - Opcode line 1010 gives vector 10
// - Line 1111 id 000 undefined: vector 11 or privilege
// - Line 1111 nonzero id probes coprocessor; fault gives 11
// - Illegal not executed; stacks offending address
// - Privileged in user mode or coprocessor check: violation
// - Privilege violation vector 8, stacks first word address
// - Vector address is base plus vector times four
package fte_pkg;

	// Register byte offsets
	localparam logic [11:0] FTE_CTRL_OFF   = 12'h000;
	localparam logic [11:0] FTE_STAT_OFF   = 12'h004;
	localparam logic [11:0] FTE_VBASE_OFF  = 12'h008;
	localparam logic [11:0] FTE_VADDR_OFF  = 12'h00C;
	localparam logic [11:0] FTE_SPC_OFF    = 12'h010;
	localparam logic [11:0] FTE_FADDR_OFF  = 12'h014;
	localparam logic [11:0] FTE_SWORD_OFF  = 12'h018;

	// Status word field positions
	localparam int FTE_SW_T1 = 15;
	localparam int FTE_SW_T0 = 14;
	localparam int FTE_SW_S  = 13;
	localparam logic [15:0] FTE_SW_RESET = 16'h2700;

	// Control register bits
	localparam int FTE_CTRL_RELOAD = 0;

	// Vector numbers
	localparam logic [7:0] FTE_VEC_BUS   = 8'h02;
	localparam logic [7:0] FTE_VEC_ADDR  = 8'h03;
	localparam logic [7:0] FTE_VEC_ILL   = 8'h04;
	localparam logic [7:0] FTE_VEC_ZDIV  = 8'h05;
	localparam logic [7:0] FTE_VEC_CHK   = 8'h06;
	localparam logic [7:0] FTE_VEC_TRAPC = 8'h07;
	localparam logic [7:0] FTE_VEC_PRIV  = 8'h08;
	localparam logic [7:0] FTE_VEC_ALINE = 8'h0A;
	localparam logic [7:0] FTE_VEC_FLINE = 8'h0B;
	localparam logic [7:0] FTE_VEC_TRAP0 = 8'h20;

	// Opcode line fields
	localparam logic [3:0] FTE_LINE_A = 4'hA;
	localparam logic [3:0] FTE_LINE_F = 4'hF;
	localparam logic [2:0] FTE_CP_MMU = 3'h0;

	// Frame format codes
	localparam logic [3:0] FTE_FMT_NORMAL = 4'h0;
	localparam logic [3:0] FTE_FMT_TRAP   = 4'h2;
	localparam logic [3:0] FTE_FMT_SHORT  = 4'hA;
	localparam logic [3:0] FTE_FMT_LONG   = 4'hB;

	// Prefetch words before resume
	localparam logic [1:0] FTE_PREFETCH_WORDS = 2'h3;

	// Instruction event classes
	typedef enum logic [2:0] {
		FTE_TRAP_NONE, FTE_TRAP_UNCOND, FTE_TRAP_COND, FTE_TRAP_CHK,
		FTE_TRAP_DIV, FTE_TRAP_PRIV
	} fte_trap_t;

	// Decoded instruction as seen at issue
	typedef struct packed {
		logic        valid;
		logic [15:0] word;
		logic        ext_undef;
		logic        bad_ctrl_reg;
		logic        privileged;
		fte_trap_t   trap;
		logic        cond_true;
		logic [31:0] addr;
		logic [31:0] next_addr;
	} fte_insn_t;

	// Bus cycle outcome
	typedef struct packed {
		logic        done;
		logic        fault;
		logic        is_fetch;
		logic        is_breakpoint_instruction;
		logic        is_cp;
		logic        cp_priv;
		logic        mid_insn;
	} fte_bus_t;

	// Exception frame handed to the stacking logic
	typedef struct packed {
		logic [3:0]  fmt;
		logic [7:0]  vector;
		logic [31:0] pc;
		logic [31:0] fault_addr;
		logic [15:0] sword;
	} fte_frame_t;

endpackage : fte_pkg

// >>> fte_unit.sv
// Fault and trap exception unit with APB register access
//
// Decided for this implementation: the register addresses and register access over APB.
module fte_unit (
	// Clock and reset
	input  wire logic              pclk,
	input  wire logic              presetn,
	// APB slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [11:0]       paddr,
	input  wire logic [31:0]       pwdata,
	output logic                   pready,
	output logic [31:0]            prdata,
	output logic                   pslverr,
	// Instruction side
	input  wire fte_pkg::fte_insn_t insn,
	input  wire logic [31:0]       fetch_addr,
	input  wire logic              fetch_req,
	input  wire logic [31:0]       exec_addr,
	// Bus side
	input  wire fte_pkg::fte_bus_t bus,
	input  wire logic              bus_fault_input,
	input  wire logic              prefetch_used,
	input  wire logic              handler_return,
	// Stacking and fetch engine
	input  wire logic              stack_done,
	input  wire logic              vec_fetch_done,
	input  wire logic              prefetch_word_done,
	output logic                   fetch_go_q,
	output logic                   cp_cycle_q,
	output logic [2:0]             cp_id_q,
	output logic                   stack_go_q,
	output fte_pkg::fte_frame_t    frame_q,
	output logic                   vec_read_q,
	output logic [31:0]            vec_addr_q,
	output logic                   resume_q,
	output logic                   trace_pending_q,
	output logic                   halted_q,
	output logic [15:0]            status_word_q
);
	import fte_pkg::*;

	typedef enum logic [2:0] {
		FTE_IDLE, FTE_STACK, FTE_VEC, FTE_FILL, FTE_HALT
	} fte_state_t;

	fte_state_t  state_q;
	logic [31:0] vbase_q;
	logic [31:0] instr_addr_q;
	logic        pf_fault_q;
	logic [1:0]  fill_cnt_q;
	logic        reload_q;
	logic        trace_defer_q;
	logic        exc_active;

	// Vector offset: vector number times four
	function automatic logic [31:0] vec_off(input logic [7:0] v);
		vec_off = {22'h0, v, 2'h0};
	endfunction : vec_off

	// Entry status: supervisor set, both trace bits clear
	function automatic logic [15:0] entry_sw(input logic [15:0] sw);
		logic [15:0] r;
		r = sw;
		r[FTE_SW_S]  = 1'b1;
		r[FTE_SW_T1] = 1'b0;
		r[FTE_SW_T0] = 1'b0;
		entry_sw = r;
	endfunction : entry_sw

	// Decode
	wire [3:0] line   = insn.word[15:12];
	wire [2:0] cp_id  = insn.word[11:9];
	wire       user   = !status_word_q[FTE_SW_S];
	wire       tracing = status_word_q[FTE_SW_T1] | status_word_q[FTE_SW_T0];
	wire       is_aline = insn.valid && line == FTE_LINE_A;
	wire       is_fmmu  = insn.valid && line == FTE_LINE_F && cp_id == FTE_CP_MMU
		&& insn.ext_undef;
	wire       is_fcp   = insn.valid && line == FTE_LINE_F && cp_id != FTE_CP_MMU;
	wire       is_ill   = insn.valid && insn.bad_ctrl_reg;
	wire       is_priv  = insn.valid && user && insn.privileged;
	wire       trap_hit = insn.valid && (insn.trap == FTE_TRAP_UNCOND
		|| (insn.trap != FTE_TRAP_NONE && insn.trap != FTE_TRAP_PRIV
		&& insn.cond_true));
	wire       odd_fetch = fetch_req && fetch_addr[0];
	wire       data_fault = bus.done && bus.fault && !bus.is_fetch
		&& !bus.is_breakpoint_instruction && !bus.is_cp;
	wire       pf_take  = pf_fault_q && prefetch_used;
	wire       breakpoint_instruction_flt = bus.done && bus.fault && bus.is_breakpoint_instruction;
	wire       cp_flt   = bus.done && bus.fault && bus.is_cp;
	wire       cp_priv  = bus.done && !bus.fault && bus.is_cp && bus.cp_priv && user;
	wire       fault_any = data_fault || pf_take || odd_fetch;
	// Fault while already stacking a fault or reloading: double fault
	wire       dbl_fault = (exc_active || reload_q) && (bus_fault_input || odd_fetch);
	assign exc_active = state_q != FTE_IDLE && state_q != FTE_HALT
		&& (frame_q.vector == FTE_VEC_BUS || frame_q.vector == FTE_VEC_ADDR);

	wire [7:0] trap_vec =
		insn.trap == FTE_TRAP_UNCOND ? FTE_VEC_TRAP0 + {4'h0, insn.word[3:0]} :
		insn.trap == FTE_TRAP_DIV    ? FTE_VEC_ZDIV :
		insn.trap == FTE_TRAP_CHK    ? FTE_VEC_CHK : FTE_VEC_TRAPC;

	// Priority: faults, then instruction exceptions
	fte_frame_t new_frame;
	logic       take;
	always_comb begin
		take = 1'b1;
		new_frame.sword = status_word_q;
		new_frame.fault_addr = 32'h0;
		new_frame.fmt = FTE_FMT_NORMAL;
		new_frame.pc = insn.addr;
		new_frame.vector = FTE_VEC_ILL;
		if (odd_fetch || data_fault || pf_take) begin
			new_frame.vector = odd_fetch ? FTE_VEC_ADDR : FTE_VEC_BUS;
			new_frame.pc = exec_addr;
			new_frame.fault_addr = odd_fetch ? fetch_addr : 32'h0;
			new_frame.fmt = bus.mid_insn ? FTE_FMT_LONG : FTE_FMT_SHORT;
		end else if (breakpoint_instruction_flt) begin
			new_frame.vector = FTE_VEC_ILL;
			new_frame.pc = exec_addr;
		end else if (cp_flt) begin
			new_frame.vector = FTE_VEC_FLINE;
			new_frame.pc = exec_addr;
		end else if (cp_priv) begin
			new_frame.vector = FTE_VEC_PRIV;
			new_frame.pc = exec_addr;
		end else if (is_priv || (is_fmmu && user)) begin
			new_frame.vector = FTE_VEC_PRIV;
		end else if (is_ill) begin
			new_frame.vector = FTE_VEC_ILL;
		end else if (is_aline) begin
			new_frame.vector = FTE_VEC_ALINE;
		end else if (is_fmmu) begin
			new_frame.vector = FTE_VEC_FLINE;
		end else if (trap_hit) begin
			new_frame.vector = trap_vec;
			new_frame.pc = insn.next_addr;
			new_frame.fault_addr = insn.addr;
			new_frame.fmt = insn.trap == FTE_TRAP_UNCOND ? FTE_FMT_NORMAL : FTE_FMT_TRAP;
		end else begin
			take = 1'b0;
		end
	end

	// APB decode
	wire        apb_acc = psel && penable;
	wire        apb_wr  = apb_acc && pwrite;
	wire        hit_ok  = paddr <= FTE_SWORD_OFF && paddr[1:0] == 2'h0;
	wire        sw_wr   = apb_wr && pready && paddr == FTE_SWORD_OFF;
	wire [31:0] rd_mux =
		paddr == FTE_CTRL_OFF  ? {31'h0, reload_q} :
		paddr == FTE_STAT_OFF  ? {28'h0, halted_q, trace_pending_q, stack_go_q,
			state_q != FTE_IDLE} :
		paddr == FTE_VBASE_OFF ? vbase_q :
		paddr == FTE_VADDR_OFF ? vec_addr_q :
		paddr == FTE_SPC_OFF   ? frame_q.pc :
		paddr == FTE_FADDR_OFF ? frame_q.fault_addr :
		paddr == FTE_SWORD_OFF ? {16'h0, status_word_q} : 32'h0;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			prdata  <= 32'h0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && !penable;
			prdata  <= (psel && !penable && !pwrite) ? rd_mux : 32'h0;
			pslverr <= psel && !penable && !hit_ok;
		end
	end

	// Software registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			vbase_q  <= 32'h0;
			reload_q <= 1'b0;
		end else if (apb_wr && pready && hit_ok) begin
			if (paddr == FTE_VBASE_OFF)
				vbase_q <= pwdata;
			if (paddr == FTE_CTRL_OFF)
				reload_q <= pwdata[FTE_CTRL_RELOAD];
		end
	end

	// Deferred prefetch fault, held until the word is consumed
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			pf_fault_q <= 1'b0;
		else if (bus.done && bus.fault && bus.is_fetch && !bus.is_breakpoint_instruction)
			pf_fault_q <= 1'b1;
		else if (pf_take)
			pf_fault_q <= 1'b0;
	end

	// Trace of a trapping instruction waits for the handler return
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trace_defer_q   <= 1'b0;
			trace_pending_q <= 1'b0;
		end else begin
			trace_pending_q <= 1'b0;
			if (state_q == FTE_IDLE && take && trap_hit && !fault_any && tracing)
				trace_defer_q <= 1'b1;
			else if (trace_defer_q && handler_return) begin
				trace_defer_q   <= 1'b0;
				trace_pending_q <= 1'b1;
			end
		end
	end

	// Coprocessor probe for nonzero coprocessor id
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cp_cycle_q <= 1'b0;
			cp_id_q    <= 3'h0;
		end else begin
			cp_cycle_q <= state_q == FTE_IDLE && is_fcp && !take;
			if (is_fcp)
				cp_id_q <= cp_id;
		end
	end

	// Suppress the fetch bus cycle for an odd address
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			fetch_go_q <= 1'b0;
		else
			fetch_go_q <= fetch_req && !fetch_addr[0] && state_q == FTE_IDLE;
	end

	// Exception sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q       <= FTE_IDLE;
			status_word_q <= FTE_SW_RESET;
			frame_q       <= '0;
			stack_go_q    <= 1'b0;
			vec_read_q    <= 1'b0;
			vec_addr_q    <= 32'h0;
			resume_q      <= 1'b0;
			halted_q      <= 1'b0;
			fill_cnt_q    <= 2'h0;
			instr_addr_q  <= 32'h0;
		end else begin
			resume_q <= 1'b0;
			case (state_q)
			FTE_IDLE: begin
				if (reload_q && bus_fault_input) begin
					state_q  <= FTE_HALT;
					halted_q <= 1'b1;
				end else if (take) begin
					frame_q       <= new_frame;
					status_word_q <= entry_sw(status_word_q);
					instr_addr_q  <= insn.addr;
					stack_go_q    <= 1'b1;
					state_q       <= FTE_STACK;
				end else if (sw_wr) begin
					// Software load of the status word, idle only
					status_word_q <= pwdata[15:0];
				end
			end
			FTE_STACK: begin
				if (dbl_fault) begin
					state_q    <= FTE_HALT;
					stack_go_q <= 1'b0;
					halted_q   <= 1'b1;
				end else if (stack_done) begin
					stack_go_q <= 1'b0;
					vec_addr_q <= vbase_q + vec_off(frame_q.vector);
					vec_read_q <= 1'b1;
					state_q    <= FTE_VEC;
				end
			end
			FTE_VEC: begin
				if (dbl_fault) begin
					state_q    <= FTE_HALT;
					vec_read_q <= 1'b0;
					halted_q   <= 1'b1;
				end else if (vec_fetch_done) begin
					vec_read_q <= 1'b0;
					fill_cnt_q <= 2'h0;
					state_q    <= FTE_FILL;
				end
			end
			FTE_FILL: begin
				if (prefetch_word_done) begin
					if (fill_cnt_q == FTE_PREFETCH_WORDS - 2'h1) begin
						resume_q <= 1'b1;
						state_q  <= FTE_IDLE;
					end
					fill_cnt_q <= fill_cnt_q + 2'h1;
				end
			end
			FTE_HALT: begin
				halted_q <= 1'b1;
			end
			default: state_q <= FTE_IDLE;
			endcase
		end
	end

	// Assertions
	a_entry_status: assert property (@(posedge pclk) disable iff (!presetn)
		state_q == FTE_IDLE && take && !(reload_q && bus_fault_input) |=>
		status_word_q[FTE_SW_S] && !status_word_q[FTE_SW_T1] && !status_word_q[FTE_SW_T0])
		else $error("entry status not supervisor with trace clear");
	a_bus_vector: assert property (@(posedge pclk) disable iff (!presetn)
		state_q == FTE_IDLE && data_fault && !odd_fetch && !reload_q |=>
		frame_q.vector == FTE_VEC_BUS && frame_q.pc == $past(exec_addr))
		else $error("bus fault vector or pc wrong");
	a_addr_vector: assert property (@(posedge pclk) disable iff (!presetn)
		state_q == FTE_IDLE && odd_fetch && !reload_q |=>
		frame_q.vector == FTE_VEC_ADDR && !fetch_go_q)
		else $error("address fault vector wrong or fetch issued");
	a_frame_format: assert property (@(posedge pclk) disable iff (!presetn)
		state_q == FTE_IDLE && data_fault && !odd_fetch && !reload_q |=>
		frame_q.fmt == ($past(bus.mid_insn) ? FTE_FMT_LONG : FTE_FMT_SHORT))
		else $error("fault frame format wrong");
	a_double_halt: assert property (@(posedge pclk) disable iff (!presetn)
		dbl_fault && state_q == FTE_STACK |=> halted_q && !stack_go_q ##1 halted_q)
		else $error("double fault did not halt");
	a_trap_vector: assert property (@(posedge pclk) disable iff (!presetn)
		state_q == FTE_IDLE && take && new_frame.vector == trap_vec && trap_hit
		&& insn.trap == FTE_TRAP_UNCOND && !fault_any |=>
		frame_q.vector == FTE_VEC_TRAP0 + {4'h0, $past(insn.word[3:0])})
		else $error("trap vector not base plus operand");
	a_aline_vector: assert property (@(posedge pclk) disable iff (!presetn)
		state_q == FTE_IDLE && is_aline && !fault_any && !breakpoint_instruction_flt && !cp_flt && !cp_priv
		&& !is_priv && !is_ill && !reload_q |=> frame_q.vector == FTE_VEC_ALINE)
		else $error("line A vector wrong");
	a_vec_address: assert property (@(posedge pclk) disable iff (!presetn)
		state_q == FTE_STACK && stack_done && !dbl_fault |=>
		vec_read_q && vec_addr_q == vbase_q + {22'h0, frame_q.vector, 2'h0})
		else $error("vector address wrong");
	a_fill_resume: assert property (@(posedge pclk) disable iff (!presetn)
		resume_q |-> $past(state_q) == FTE_FILL)
		else $error("resume without prefetch fill");

	c_bus_fault: cover property (@(posedge pclk) disable iff (!presetn)
		state_q == FTE_IDLE && data_fault ##[1:40] resume_q);
	c_trap: cover property (@(posedge pclk) disable iff (!presetn)
		state_q == FTE_IDLE && trap_hit && take);
	c_double: cover property (@(posedge pclk) disable iff (!presetn) halted_q);
	c_trace: cover property (@(posedge pclk) disable iff (!presetn) trace_pending_q);

endmodule : fte_unit

// >>> fte_engine_model.sv
// Model of the stacking, vector fetch and bus termination logic beside the unit
module fte_engine_model (
	// Clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// Bench controls
	input  wire logic slow,
	input  wire logic fault_stack,
	// Requests from the unit
	input  wire logic stack_go_q,
	input  wire logic vec_read_q,
	// Answers to the unit
	output logic      stack_done,
	output logic      vec_fetch_done,
	output logic      prefetch_word_done,
	output logic      bus_fault_input
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		stack_done         = 1'b0;
		vec_fetch_done     = 1'b0;
		prefetch_word_done = 1'b0;
		bus_fault_input    = 1'b0;
	end

	task automatic pause;
		repeat (slow ? 4 : 1) @(posedge pclk);
	endtask : pause

	always begin
		@(posedge pclk);
		if (presetn === 1'b1 && stack_go_q === 1'b1) begin
			pause();
			if (fault_stack) begin
				// Stacking cycle ended by a bus fault
				bus_fault_input <= 1'b1;
				@(posedge pclk);
				bus_fault_input <= 1'b0;
			end else begin
				stack_done <= 1'b1;
				@(posedge pclk);
				stack_done <= 1'b0;
				while (vec_read_q !== 1'b1) @(posedge pclk);
				pause();
				vec_fetch_done <= 1'b1;
				@(posedge pclk);
				vec_fetch_done <= 1'b0;
				repeat (3) begin
					pause();
					prefetch_word_done <= 1'b1;
					@(posedge pclk);
					prefetch_word_done <= 1'b0;
				end
			end
		end
	end
endmodule : fte_engine_model

// >>> fte_unit_tb.sv
// Self-checking testbench for the fault and trap exception unit
module fte_unit_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import fte_pkg::*;

	localparam logic [31:0] IA = 32'h0000_2000;
	localparam logic [31:0] EA = 32'h0000_3000;
	localparam logic [31:0] VB = 32'h0000_1000;

	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, fetch_addr = 32'h0, exec_addr = EA, prdata, vec_addr_q;
	logic        fetch_req = 1'b0, prefetch_used = 1'b0, handler_return = 1'b0;
	logic        slow = 1'b0, fault_stack = 1'b0, pready, pslverr, fetch_go_q, cp_cycle_q;
	logic        stack_go_q, vec_read_q, resume_q, trace_pending_q, halted_q;
	logic        stack_done, vec_fetch_done, prefetch_word_done, bus_fault_input;
	logic [2:0]  cp_id_q;
	logic [15:0] status_word_q;
	logic [15:0] sw_exp = FTE_SW_RESET;
	fte_insn_t   insn = '0;
	fte_bus_t    bus = '0;
	fte_frame_t  frame_q;
	wire logic [4:0] flags = {halted_q, cp_cycle_q, resume_q, vec_read_q, stack_go_q};
	int          num_checks = 0, miscompares = 0;

	always #2 pclk = ~pclk;

	fte_unit u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .insn(insn), .fetch_addr(fetch_addr), .fetch_req(fetch_req),
		.exec_addr(exec_addr), .bus(bus), .bus_fault_input(bus_fault_input),
		.prefetch_used(prefetch_used), .handler_return(handler_return),
		.stack_done(stack_done), .vec_fetch_done(vec_fetch_done),
		.prefetch_word_done(prefetch_word_done), .fetch_go_q(fetch_go_q),
		.cp_cycle_q(cp_cycle_q), .cp_id_q(cp_id_q), .stack_go_q(stack_go_q),
		.frame_q(frame_q), .vec_read_q(vec_read_q), .vec_addr_q(vec_addr_q),
		.resume_q(resume_q), .trace_pending_q(trace_pending_q), .halted_q(halted_q),
		.status_word_q(status_word_q));

	fte_engine_model u_engine (.pclk(pclk), .presetn(presetn), .slow(slow),
		.fault_stack(fault_stack), .stack_go_q(stack_go_q), .vec_read_q(vec_read_q),
		.stack_done(stack_done), .vec_fetch_done(vec_fetch_done),
		.prefetch_word_done(prefetch_word_done), .bus_fault_input(bus_fault_input));

	task automatic finish_test;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : finish_test

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic wait_for(input int b, input string what);
		int n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (flags[b] !== 1'b1 && n < 200);
		check({what, " wait"}, 32'(flags[b]), 32'h1);
	endtask : wait_for

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		int n = 0;
		@(posedge pclk);
		psel    <= 1'b1;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		check("apb ready", 32'(pready), 32'h1);
	endtask : apb

	task automatic issue(input fte_insn_t i, input fte_bus_t b);
		@(posedge pclk);
		insn <= i;
		bus  <= b;
		@(posedge pclk);
		insn <= '0;
		bus  <= '0;
	endtask : issue

	function automatic fte_insn_t mk(input logic [15:0] w, input logic e, input logic bad,
		input fte_trap_t t, input logic c);
		mk = '{valid: 1'b1, word: w, ext_undef: e, bad_ctrl_reg: bad, privileged: 1'b0,
			trap: t, cond_true: c, addr: IA, next_addr: IA + 32'h4};
	endfunction : mk

	// Flags: bit0 pc, bit1 format, bit2 trapping address
	task automatic expect_exc(input string what, input logic [7:0] vec, input logic [31:0] pc,
		input logic [3:0] fmt, input logic [2:0] fl);
		wait_for(0, what);
		check({what, " vector"}, 32'(frame_q.vector), 32'(vec));
		if (fl[0]) check({what, " pc"}, frame_q.pc, pc);
		if (fl[1]) check({what, " format"}, 32'(frame_q.fmt), 32'(fmt));
		if (fl[2]) check({what, " trap addr"}, frame_q.fault_addr, IA);
		check({what, " saved status"}, 32'(frame_q.sword), 32'(sw_exp));
		check({what, " status"}, 32'(status_word_q[15:13]), 32'h1);
		sw_exp = {3'h1, sw_exp[12:0]};
		wait_for(1, what);
		check({what, " vec addr"}, vec_addr_q, VB + {22'h0, vec, 2'h0});
		wait_for(2, what);
	endtask : expect_exc

	task automatic set_sw(input logic [15:0] v);
		logic [31:0] rd;
		logic        err;
		apb(1'b1, FTE_SWORD_OFF, {16'h0, v}, rd, err);
		sw_exp = v;
	endtask : set_sw

	task automatic restart;
		presetn <= 1'b0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		sw_exp = FTE_SW_RESET;
		@(posedge pclk);
		check("reset restart", 32'(halted_q), 32'h0);
	endtask : restart

	task automatic t_regs;
		logic [31:0] rd;
		logic        err;
		check("status reset", 32'(status_word_q), 32'h2700);
		apb(1'b1, FTE_VBASE_OFF, VB, rd, err);
		apb(1'b0, FTE_VBASE_OFF, 32'h0, rd, err);
		check("vbase", rd, VB);
		set_sw(16'h0700);
		apb(1'b0, FTE_SWORD_OFF, 32'h0, rd, err);
		check("status load", rd, 32'h0000_0700);
		apb(1'b0, 12'h0FC, 32'h0, rd, err);
		check("unmapped err", 32'(err), 32'h1);
		$display("register test done");
	endtask : t_regs

	task automatic t_bus;
		issue('0, '{done: 1'b1, fault: 1'b1, default: 1'b0});
		expect_exc("data fault", FTE_VEC_BUS, EA, FTE_FMT_SHORT, 3'h3);
		slow <= 1'b1;
		issue('0, '{done: 1'b1, fault: 1'b1, mid_insn: 1'b1, default: 1'b0});
		expect_exc("mid fault", FTE_VEC_BUS, EA, FTE_FMT_LONG, 3'h3);
		slow <= 1'b0;
		issue('0, '{done: 1'b1, fault: 1'b1, is_fetch: 1'b1, default: 1'b0});
		repeat (6) @(posedge pclk);
		check("deferred", 32'(stack_go_q), 32'h0);
		@(posedge pclk);
		prefetch_used <= 1'b1;
		@(posedge pclk);
		prefetch_used <= 1'b0;
		expect_exc("used fetch", FTE_VEC_BUS, EA, 4'h0, 3'h1);
		issue('0, '{done: 1'b1, fault: 1'b1, is_breakpoint_instruction: 1'b1, default: 1'b0});
		expect_exc("breakpoint_instruction fault", FTE_VEC_ILL, 32'h0, 4'h0, 3'h0);
		$display("bus fault test done");
	endtask : t_bus

	task automatic t_odd;
		@(posedge pclk);
		fetch_req  <= 1'b1;
		fetch_addr <= 32'h100;
		repeat (2) @(posedge pclk);
		check("even fetch", 32'(fetch_go_q), 32'h1);
		fetch_addr <= 32'h101;
		@(posedge pclk);
		fetch_req  <= 1'b0;
		@(posedge pclk);
		check("odd fetch", 32'(fetch_go_q), 32'h0);
		expect_exc("odd fetch", FTE_VEC_ADDR, EA, 4'h0, 3'h1);
		$display("address fault test done");
	endtask : t_odd

	task automatic t_insn;
		logic [15:0] w[9] = '{16'hA123, 16'h4E7B, 16'hF000, 16'h4E4F, 16'h4E40, 16'h50FC,
			16'h4180, 16'h80C0, 16'h4E76};
		fte_trap_t   t[9] = '{FTE_TRAP_NONE, FTE_TRAP_NONE, FTE_TRAP_NONE, FTE_TRAP_UNCOND,
			FTE_TRAP_UNCOND, FTE_TRAP_COND, FTE_TRAP_CHK, FTE_TRAP_DIV, FTE_TRAP_COND};
		logic [7:0]  v[9] = '{FTE_VEC_ALINE, FTE_VEC_ILL, FTE_VEC_FLINE, 8'h2F, FTE_VEC_TRAP0,
			FTE_VEC_TRAPC, FTE_VEC_CHK, FTE_VEC_ZDIV, FTE_VEC_TRAPC};
		for (int i = 0; i < 9; i++) begin
			issue(mk(w[i], i == 2, i == 1, t[i], 1'b1), '0);
			expect_exc("insn", v[i], (i < 3) ? IA : IA + 32'h4, 4'h0,
				{i > 4, 2'h1});
		end
		issue(mk(16'h50FC, 1'b0, 1'b0, FTE_TRAP_COND, 1'b0), '0);
		repeat (6) @(posedge pclk);
		check("false cond", 32'(stack_go_q), 32'h0);
		issue(mk(16'hF200, 1'b0, 1'b0, FTE_TRAP_NONE, 1'b1), '0);
		wait_for(3, "cp probe");
		check("cp id", 32'(cp_id_q), 32'h1);
		issue('0, '{done: 1'b1, fault: 1'b1, is_cp: 1'b1, default: 1'b0});
		expect_exc("cp fault", FTE_VEC_FLINE, 32'h0, 4'h0, 3'h0);
		$display("instruction test done");
	endtask : t_insn

	task automatic t_priv;
		fte_insn_t p;
		p = mk(16'h4E73, 1'b0, 1'b0, FTE_TRAP_NONE, 1'b1);
		p.privileged = 1'b1;
		set_sw(16'h0000);
		issue(p, '0);
		expect_exc("privileged", FTE_VEC_PRIV, IA, 4'h0, 3'h1);
		set_sw(16'h0000);
		issue(mk(16'hF000, 1'b1, 1'b0, FTE_TRAP_NONE, 1'b1), '0);
		expect_exc("user fline", FTE_VEC_PRIV, IA, 4'h0, 3'h1);
		set_sw(16'h0000);
		issue('0, '{done: 1'b1, is_cp: 1'b1, cp_priv: 1'b1, default: 1'b0});
		expect_exc("cp check", FTE_VEC_PRIV, EA, 4'h0, 3'h1);
		set_sw(16'h8000);
		issue(mk(16'h4E41, 1'b0, 1'b0, FTE_TRAP_UNCOND, 1'b1), '0);
		expect_exc("traced trap", FTE_VEC_TRAP0 + 8'h01, IA + 32'h4, 4'h0, 3'h1);
		check("trace held", 32'(trace_pending_q), 32'h0);
		handler_return <= 1'b1;
		@(posedge pclk);
		handler_return <= 1'b0;
		@(posedge pclk);
		check("trace after return", 32'(trace_pending_q), 32'h1);
		$display("privilege and trace test done");
	endtask : t_priv

	task automatic t_halt;
		logic [31:0] rd;
		logic        err;
		slow        <= 1'b1;
		fault_stack <= 1'b1;
		issue('0, '{done: 1'b1, fault: 1'b1, default: 1'b0});
		wait_for(4, "double fault");
		issue(mk(16'hA000, 1'b0, 1'b0, FTE_TRAP_NONE, 1'b1), '0);
		repeat (20) @(posedge pclk);
		check("sticky halt", 32'(halted_q), 32'h1);
		apb(1'b0, FTE_STAT_OFF, 32'h0, rd, err);
		check("stat halted", 32'(rd[3]), 32'h1);
		restart();
		apb(1'b1, FTE_CTRL_OFF, 32'h1, rd, err);
		issue(mk(16'h4E40, 1'b0, 1'b0, FTE_TRAP_UNCOND, 1'b1), '0);
		wait_for(4, "reload fault");
		fault_stack <= 1'b0;
		restart();
		issue('0, '{done: 1'b1, fault: 1'b1, default: 1'b0});
		wait_for(0, "second fault");
		fetch_req  <= 1'b1;
		fetch_addr <= 32'h201;
		@(posedge pclk);
		fetch_req  <= 1'b0;
		wait_for(4, "odd in fault");
		$display("halt test done");
	endtask : t_halt

	initial begin
		repeat (20000) @(posedge pclk);
		miscompares++;
		finish_test();
	end

	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_regs();
		t_bus();
		t_odd();
		t_insn();
		t_priv();
		t_halt();
		finish_test();
	end
endmodule : fte_unit_tb
